// File: hdl/apcd_pkg.sv
package apcd_pkg;
  // Frame layout: address, instruction, type, bank, four value bytes, checksum
  localparam int FRAME_BYTES = 9;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_INSTR = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;
  localparam logic [3:0] IDX_CSUM = 4'h8;
  localparam logic [3:0] IDX_LAST_VALUE = 4'h7;
  // Instruction codes
  localparam logic [7:0] INSTR_MOVE = 8'h04;
  localparam logic [7:0] INSTR_SET = 8'h05;
  localparam logic [7:0] INSTR_GET = 8'h06;
  localparam logic [7:0] INSTR_STORE = 8'h07;
  localparam logic [7:0] INSTR_RESTORE = 8'h08;
  // Move type selecting a stored coordinate
  localparam logic [7:0] MOVE_TYPE_STORED_COORDINATE_TYPE = 8'h02;
  // Reply status codes
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  // Parameter numbers with fixed meaning
  localparam logic [7:0] PARAM_ACT_POS = 8'h01;
  localparam logic [7:0] PARAM_MAX_SPEED = 8'h04;
  // Default address and sizes
  localparam logic [7:0] DEFAULT_ADDR = 8'h01;
  localparam int PARAM_COUNT = 256;
  localparam int REPLY_BYTES = 9;
  localparam logic [31:0] VALUE_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_NV_WAIT = 3'b011,
    ST_READ = 3'b100,
    ST_REPLY = 3'b101
  } apcd_state_type;
endpackage : apcd_pkg

// File: hdl/apcd_param_ram.sv
`timescale 1ns/1ps
// Single port parameter store with registered read data
module apcd_param_ram
  import apcd_pkg::*;
#(
  parameter int DEPTH = PARAM_COUNT,
  parameter int AW = 8
)(
  input wire logic REF_CLK,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata_q
);
  // Volatile cells, contents undefined until loaded
  logic [31:0] mem [DEPTH];

  // Read first, read data registered
  always_ff @(posedge REF_CLK)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end
endmodule : apcd_param_ram

// File: hdl/apcd_frame_rx.sv
`timescale 1ns/1ps
// Collects nine bytes, checks address and checksum, holds the frame
module apcd_frame_rx
  import apcd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic accept,
  input wire logic [7:0] own_addr,
  output logic frame_valid_q,
  output logic [7:0] instr_q,
  output logic [7:0] type_q,
  output logic [7:0] bank_q,
  output logic [31:0] value_q
);
  logic [3:0] idx_q;
  logic [7:0] sum_q;
  logic [7:0] addr_q;
  // Last byte of a frame is the checksum
  wire last_byte = byte_valid && (idx_q == IDX_CSUM);
  wire sum_ok = (sum_q == byte_data);
  wire addr_ok = (addr_q == own_addr);

  // Byte collector; bytes arriving while busy are dropped and the byte index holds
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      idx_q <= 4'h0;
      sum_q <= 8'h00;
      addr_q <= 8'h00;
      instr_q <= 8'h00;
      type_q <= 8'h00;
      bank_q <= 8'h00;
      value_q <= VALUE_ZERO;
      frame_valid_q <= 1'b0;
    end
    else
    begin
      frame_valid_q <= 1'b0;
      if (byte_valid && accept)
      begin
        // Running modulo 256 sum
        sum_q <= (idx_q == IDX_ADDR) ? byte_data : 8'(sum_q + byte_data);
        idx_q <= last_byte ? 4'h0 : 4'(idx_q + 4'h1);
        if (idx_q == IDX_ADDR) addr_q <= byte_data;
        else if (idx_q == IDX_INSTR) instr_q <= byte_data;
        else if (idx_q == IDX_TYPE) type_q <= byte_data;
        else if (idx_q == IDX_BANK) bank_q <= byte_data;
        else if (idx_q <= IDX_LAST_VALUE) value_q <= {value_q[23:0], byte_data};
        // Only well summed frames for this node pass
        if (last_byte && sum_ok && addr_ok) frame_valid_q <= 1'b1;
      end
    end
  end
endmodule : apcd_frame_rx

// File: hdl/apcd_decoder.sv
`timescale 1ns/1ps
module apcd_decoder
  import apcd_pkg::*;
#(
  parameter logic [7:0] NODE_ADDR = DEFAULT_ADDR,
  parameter int AW = 8
)(
  input wire logic REF_CLK,
  input wire logic RST,
  // Received bytes of the host link
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  // Reply bytes toward the link
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Operating mode: high lets a get load the accumulator
  input wire logic STANDALONE,
  // Non-volatile store port, one word per request
  output logic NV_REQ,
  output logic NV_WRITE,
  output logic [7:0] NV_ADDR,
  output logic [31:0] NV_WDATA,
  input wire logic NV_ACK,
  input wire logic [31:0] NV_RDATA,
  // Actual axis position from the motion core
  input wire logic [31:0] ACT_POS,
  // Stored coordinate lookup for moves
  output logic [7:0] STORED_COORDINATE_TYPE_SEL,
  input wire logic [31:0] STORED_COORDINATE_TYPE_VALUE,
  // Move request to motion core
  output logic MOVE_START,
  output logic [31:0] MOVE_TARGET,
  output logic [31:0] MAX_SPEED,
  output logic [31:0] ACCU
);
  apcd_state_type state_q, state_d;
  logic [7:0] boot_idx_q;
  logic boot_last_q;
  logic [31:0] reply_val_q;
  logic [7:0] reply_stat_q;
  logic [3:0] tx_idx_q;
  logic [7:0] tx_sum_q;
  logic nv_pend_q;
  logic [31:0] accu_q;
  logic [31:0] speed_q;
  logic move_q;
  logic [31:0] target_q;
  logic [7:0] nv_addr_q;
  logic nv_wr_q;
  logic [31:0] nv_wdata_q;
  // Decoded frame fields
  logic frame_valid;
  logic [7:0] instr;
  logic [7:0] ptype;
  logic [7:0] bank;
  logic [31:0] value;
  logic [31:0] ram_rdata;

  // Receiver accepts bytes only in ST_IDLE, which blocks overlap with replies
  wire rx_accept = (state_q == ST_IDLE);
  apcd_frame_rx u_rx (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .byte_valid(RX_VALID),
    .byte_data(RX_DATA),
    .accept(rx_accept),
    .own_addr(NODE_ADDR),
    .frame_valid_q(frame_valid),
    .instr_q(instr),
    .type_q(ptype),
    .bank_q(bank),
    .value_q(value)
  );

  // Command class decode
  wire is_set = (instr == INSTR_SET);
  wire is_get = (instr == INSTR_GET);
  wire is_store = (instr == INSTR_STORE);
  wire is_restore = (instr == INSTR_RESTORE);
  wire is_move = (instr == INSTR_MOVE) && (ptype == MOVE_TYPE_STORED_COORDINATE_TYPE);
  wire known = is_set || is_get || is_store || is_restore || is_move;
  // Write into the volatile store: set, restore, and boot loading
  wire boot_wr = (state_q == ST_BOOT) && nv_pend_q && NV_ACK;
  wire rest_wr = (state_q == ST_NV_WAIT) && is_restore && NV_ACK;
  wire ram_we = ((state_q == ST_EXEC) && is_set) || boot_wr || rest_wr;
  wire [AW-1:0] ram_addr = (state_q == ST_BOOT) ? boot_idx_q : ptype;
  wire [31:0] ram_wdata = (state_q == ST_EXEC) ? value : NV_RDATA;
  // Actual position is read live rather than from the store
  wire [31:0] get_value = (ptype == PARAM_ACT_POS) ? ACT_POS : ram_rdata;
  wire tx_fire = (state_q == ST_REPLY) && TX_READY;
  wire tx_last = tx_fire && (tx_idx_q == IDX_CSUM);

  // Volatile parameter cells
  apcd_param_ram #(.DEPTH(PARAM_COUNT), .AW(AW)) u_ram (
    .REF_CLK(REF_CLK),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata_q(ram_rdata)
  );

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_BOOT:
        if (boot_wr && boot_last_q) state_d = ST_IDLE;
      ST_IDLE:
        if (frame_valid) state_d = ST_EXEC;
      ST_EXEC:
        if (known && (is_store || is_restore)) state_d = ST_NV_WAIT;
        else if (known && is_get) state_d = ST_READ;
        else state_d = ST_REPLY;
      ST_NV_WAIT:
        if (NV_ACK) state_d = ST_REPLY;
      ST_READ:
        state_d = ST_REPLY;
      ST_REPLY:
        if (tx_last) state_d = ST_IDLE;
      default:
        state_d = ST_BOOT;
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK)
  begin
    if (RST) state_q <= ST_BOOT;
    else state_q <= state_d;
  end

  // Boot loader walks every parameter from the non-volatile copy
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      boot_idx_q <= 8'h00;
      boot_last_q <= 1'b0;
    end
    else if (boot_wr)
    begin
      boot_idx_q <= 8'(boot_idx_q + 8'h01);
      boot_last_q <= (boot_idx_q == 8'(PARAM_COUNT - 2));
    end
  end

  // Non-volatile request; held until acknowledged
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      nv_pend_q <= 1'b0;
      nv_wr_q <= 1'b0;
      nv_addr_q <= 8'h00;
      nv_wdata_q <= VALUE_ZERO;
    end
    else if (nv_pend_q)
    begin
      // Drop one cycle after ack so a fresh word is fetched
      if (NV_ACK) nv_pend_q <= 1'b0;
    end
    else if (state_q == ST_BOOT && !boot_wr)
    begin
      nv_pend_q <= 1'b1;
      nv_wr_q <= 1'b0;
      nv_addr_q <= boot_idx_q;
    end
    else if (state_q == ST_EXEC && (is_store || is_restore))
    begin
      nv_pend_q <= 1'b1;
      nv_wr_q <= is_store;
      nv_addr_q <= ptype;
      // Stored word comes from the volatile cell, or live ACT_POS for PARAM_ACT_POS, not the value field
      nv_wdata_q <= get_value;
    end
  end

  // Reply contents and side effects of commands
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      reply_stat_q <= STATUS_OK;
      reply_val_q <= VALUE_ZERO;
      accu_q <= VALUE_ZERO;
      speed_q <= VALUE_ZERO;
      move_q <= 1'b0;
      target_q <= VALUE_ZERO;
    end
    else
    begin
      move_q <= 1'b0;
      if (state_q == ST_EXEC)
      begin
        // Unknown instruction or move type answers with an error status
        reply_stat_q <= !known ? ((instr == INSTR_MOVE) ? STATUS_BAD_TYPE : STATUS_BAD_CMD)
                                : STATUS_OK;
        reply_val_q <= VALUE_ZERO;
        if (is_set && ptype == PARAM_MAX_SPEED) speed_q <= value;
        if (is_move)
        begin
          move_q <= 1'b1;
          target_q <= STORED_COORDINATE_TYPE_VALUE;
        end
      end
      if (state_q == ST_READ)
      begin
        reply_val_q <= get_value;
        if (STANDALONE) accu_q <= get_value;
      end
      if (rest_wr && ptype == PARAM_MAX_SPEED) speed_q <= NV_RDATA;
      if (boot_wr && boot_idx_q == PARAM_MAX_SPEED) speed_q <= NV_RDATA;
    end
  end

  // Reply serialiser: host address, own address, status, instruction, value, sum
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      tx_idx_q <= 4'h0;
      tx_sum_q <= 8'h00;
    end
    else if (tx_fire)
    begin
      tx_idx_q <= tx_last ? 4'h0 : 4'(tx_idx_q + 4'h1);
      tx_sum_q <= tx_last ? 8'h00 : 8'(tx_sum_q + TX_DATA);
    end
  end

  // Reply byte selection
  always_comb
  begin
    case (tx_idx_q)
      4'h0: TX_DATA = DEFAULT_ADDR;
      4'h1: TX_DATA = NODE_ADDR;
      4'h2: TX_DATA = reply_stat_q;
      4'h3: TX_DATA = instr;
      4'h4: TX_DATA = reply_val_q[31:24];
      4'h5: TX_DATA = reply_val_q[23:16];
      4'h6: TX_DATA = reply_val_q[15:8];
      4'h7: TX_DATA = reply_val_q[7:0];
      default: TX_DATA = tx_sum_q;
    endcase
  end

  assign TX_VALID = (state_q == ST_REPLY);
  assign NV_REQ = nv_pend_q;
  assign NV_WRITE = nv_wr_q;
  assign NV_ADDR = nv_addr_q;
  assign NV_WDATA = nv_wdata_q;
  assign STORED_COORDINATE_TYPE_SEL = value[7:0];
  assign MOVE_START = move_q;
  assign MOVE_TARGET = target_q;
  assign MAX_SPEED = speed_q;
  assign ACCU = accu_q;
  // Bank byte is assumed zero by the host and is not checked
  wire unused_bank = ^bank;
endmodule : apcd_decoder

// File: tb/apcd_decoder_properties.sv
`timescale 1ns/1ps
// Port-level timing checks for the command decoder
module apcd_decoder_chk
  import apcd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic STANDALONE,
  input wire logic NV_REQ,
  input wire logic [7:0] NV_ADDR,
  input wire logic NV_ACK,
  input wire logic [31:0] STORED_COORDINATE_TYPE_VALUE,
  input wire logic MOVE_START,
  input wire logic [31:0] MOVE_TARGET,
  input wire logic [31:0] ACCU
);
  logic [3:0] sent_q; // Reply bytes taken so far
  // Wraps after the ninth byte, so a reply can be told apart from the next
  always_ff @(posedge REF_CLK)
  begin
    if (RST || (TX_VALID && TX_READY && sent_q == 4'h8))
      sent_q <= 4'h0;
    else if (TX_VALID && TX_READY)
      sent_q <= sent_q + 4'h1;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_nv_hold: assert property (NV_REQ && !NV_ACK |=> NV_REQ && $stable(NV_ADDR))
    else $error("nv request changed before ack");
  chk_nv_drop: assert property (NV_REQ && NV_ACK |=> !NV_REQ)
    else $error("nv request held after ack");
  chk_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte changed while stalled");
  chk_tx_nine: assert property (TX_VALID && TX_READY && sent_q == 4'h8 |=> !TX_VALID)
    else $error("reply longer than nine bytes");
  chk_move_pulse: assert property (MOVE_START |=> !MOVE_START)
    else $error("move start longer than one cycle");
  chk_move_target: assert property (MOVE_START |-> MOVE_TARGET == STORED_COORDINATE_TYPE_VALUE)
    else $error("move target differs from coordinate");
  chk_accu_keep: assert property (!STANDALONE [*2] |-> $stable(ACCU))
    else $error("accumulator changed in direct mode");
  chk_boot_quiet: assert property ($fell(RST) |-> !TX_VALID [*8])
    else $error("reply during boot");
  cov_move: cover property (MOVE_START);
  cov_nv: cover property (NV_REQ && NV_ACK);
  cov_stall: cover property (TX_VALID && !TX_READY);
endmodule : apcd_decoder_chk
bind apcd_decoder apcd_decoder_chk apcd_decoder_chk_inst (.REF_CLK(REF_CLK), .RST(RST),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .STANDALONE(STANDALONE),
  .NV_REQ(NV_REQ), .NV_ADDR(NV_ADDR), .NV_ACK(NV_ACK), .STORED_COORDINATE_TYPE_VALUE(STORED_COORDINATE_TYPE_VALUE),
  .MOVE_START(MOVE_START), .MOVE_TARGET(MOVE_TARGET), .ACCU(ACCU));

// File: tb/apcd_nv_model.sv
`timescale 1ns/1ps
// Non-volatile parameter memory; odd words answer slowly
module apcd_nv_model
  import apcd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NV_REQ,
  input wire logic NV_WRITE,
  input wire logic [7:0] NV_ADDR,
  input wire logic [31:0] NV_WDATA,
  output logic NV_ACK,
  output logic [31:0] NV_RDATA
);
  logic [31:0] mem [PARAM_COUNT]; // Survives design reset
  logic [1:0] wait_q; // Cycles spent on this request
  // Distinct contents per word so a wrong address shows
  initial
  begin
    for (int i = 0; i < PARAM_COUNT; i++)
      mem[i] = {24'ha5a500, i[7:0]};
    NV_ACK = 1'b0;
    NV_RDATA = 32'h0;
    wait_q = 2'h0;
  end
  // One word per request
  always @(posedge REF_CLK)
  begin
    if (NV_REQ && !NV_ACK && wait_q >= {NV_ADDR[0], 1'b1})
    begin
      NV_ACK <= 1'b1;
      NV_RDATA <= mem[NV_ADDR];
      if (NV_WRITE)
        mem[NV_ADDR] <= NV_WDATA;
    end
    else
    begin
      NV_ACK <= 1'b0;
      NV_RDATA <= ~NV_RDATA; // Not valid outside the ack cycle
    end
    wait_q <= (NV_REQ && !NV_ACK) ? wait_q + 2'h1 : 2'h0;
  end
endmodule : apcd_nv_model

// File: tb/apcd_decoder_tb.sv
`timescale 1ns/1ps
// Sends command frames and judges the replies
module apcd_decoder_tb
  import apcd_pkg::*;
;
  logic REF_CLK, RST, RX_VALID, TX_READY, STANDALONE, TX_VALID;
  logic NV_REQ, NV_WRITE, NV_ACK, MOVE_START, moved_q;
  logic [7:0] RX_DATA, TX_DATA, NV_ADDR, STORED_COORDINATE_TYPE_SEL;
  logic [31:0] ACT_POS, NV_WDATA, NV_RDATA, STORED_COORDINATE_TYPE_VALUE, MOVE_TARGET, MAX_SPEED, ACCU;
  logic [31:0] moved_target; // Target seen with the last move pulse
  logic [7:0] exp_stat; // Status byte the next reply must carry
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int acks = 0; // Words loaded since the last reset
  // Loaded coordinate store
  assign STORED_COORDINATE_TYPE_VALUE = {24'hc00000, STORED_COORDINATE_TYPE_SEL};
  apcd_decoder apcd_decoder_inst (.REF_CLK(REF_CLK), .RST(RST), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .STANDALONE(STANDALONE), .NV_REQ(NV_REQ), .NV_WRITE(NV_WRITE), .NV_ADDR(NV_ADDR),
    .NV_WDATA(NV_WDATA), .NV_ACK(NV_ACK), .NV_RDATA(NV_RDATA), .ACT_POS(ACT_POS),
    .STORED_COORDINATE_TYPE_SEL(STORED_COORDINATE_TYPE_SEL), .STORED_COORDINATE_TYPE_VALUE(STORED_COORDINATE_TYPE_VALUE), .MOVE_START(MOVE_START),
    .MOVE_TARGET(MOVE_TARGET), .MAX_SPEED(MAX_SPEED), .ACCU(ACCU));
  apcd_nv_model apcd_nv_model_inst (.REF_CLK(REF_CLK), .NV_REQ(NV_REQ), .NV_WRITE(NV_WRITE),
    .NV_ADDR(NV_ADDR), .NV_WDATA(NV_WDATA), .NV_ACK(NV_ACK), .NV_RDATA(NV_RDATA));
  initial
  begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // Boot progress, move capture and hang guard
  always @(posedge REF_CLK)
  begin
    cycles <= cycles + 1;
    if (NV_ACK)
      acks <= acks + 1;
    if (MOVE_START)
      moved_q <= 1'b1;
    if (MOVE_START)
      moved_target <= MOVE_TARGET;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // Reset, then wait out the load of every parameter word
  task automatic do_reset();
    acks = 0;
    RST <= 1'b1;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 4000 && acks < PARAM_COUNT; i++)
      @(posedge REF_CLK);
    repeat (3) @(posedge REF_CLK);
  endtask : do_reset
  // Back-to-back bytes; bad is folded into the checksum
  task automatic send(input logic [7:0] adr, ins, typ, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] b [9];
    b = '{adr, ins, typ, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], bad};
    for (int i = 0; i < 8; i++)
      b[8] += b[i];
    for (int i = 0; i < 9; i++)
    begin
      @(posedge REF_CLK);
      RX_VALID <= 1'b1;
      RX_DATA <= b[i];
    end
    @(posedge REF_CLK);
    RX_VALID <= 1'b0;
  endtask : send
  // Takes one reply, stalling every third cycle
  task automatic reply(input logic [7:0] ins, input logic [31:0] v);
    logic [7:0] e [9];
    int n;
    e = '{8'h01, DEFAULT_ADDR, exp_stat, ins, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      e[8] += e[i];
    n = 0;
    for (int i = 0; i < 200 && n < 9; i++)
    begin
      @(posedge REF_CLK);
      if (TX_VALID === 1'b1 && TX_READY === 1'b1)
      begin
        chk("reply byte", {24'h0, e[n]}, {24'h0, TX_DATA});
        n++;
      end
      TX_READY <= (i % 3) != 1;
    end
    chk("reply bytes", 32'd9, 32'(n));
    TX_READY <= 1'b0;
  endtask : reply
  task automatic no_reply();
    int seen;
    seen = 0;
    repeat (30)
    begin
      @(posedge REF_CLK);
      if (TX_VALID !== 1'b0)
        seen++;
    end
    chk("silent", 32'h0, 32'(seen));
  endtask : no_reply
  task automatic t_set_get();
    chk("boot speed", 32'ha5a50004, MAX_SPEED);
    send(8'h01, INSTR_SET, PARAM_MAX_SPEED, 32'h3e8, 8'h00);
    reply(INSTR_SET, 32'h0);
    chk("speed", 32'h3e8, MAX_SPEED);
    send(8'h01, INSTR_GET, PARAM_MAX_SPEED, 32'h0, 8'h00);
    reply(INSTR_GET, 32'h3e8);
    chk("accu kept", 32'h0, ACCU);
  endtask : t_set_get
  task automatic t_position();
    ACT_POS <= 32'h87654321;
    STANDALONE <= 1'b1;
    send(8'h01, INSTR_GET, PARAM_ACT_POS, 32'h0, 8'h00);
    reply(INSTR_GET, 32'h87654321);
    chk("accu load", 32'h87654321, ACCU);
    STANDALONE <= 1'b0;
  endtask : t_position
  task automatic t_store_restore();
    send(8'h01, INSTR_SET, 8'h06, 32'h0badcafe, 8'h00);
    reply(INSTR_SET, 32'h0);
    send(8'h01, INSTR_STORE, 8'h06, 32'hffffffff, 8'h00);
    reply(INSTR_STORE, 32'h0);
    chk("nv copy", 32'h0badcafe, apcd_nv_model_inst.mem[6]);
    send(8'h01, INSTR_SET, 8'h06, 32'h11112222, 8'h00);
    reply(INSTR_SET, 32'h0);
    send(8'h01, INSTR_RESTORE, 8'h06, 32'h5, 8'h00);
    reply(INSTR_RESTORE, 32'h0);
    send(8'h01, INSTR_GET, 8'h06, 32'h0, 8'h00);
    reply(INSTR_GET, 32'h0badcafe);
  endtask : t_store_restore
  task automatic t_move();
    moved_q = 1'b0;
    send(8'h01, INSTR_MOVE, MOVE_TYPE_STORED_COORDINATE_TYPE, 32'h8, 8'h00);
    reply(INSTR_MOVE, 32'h0);
    chk("moved", 32'h1, {31'h0, moved_q});
    chk("target", 32'hc0000008, moved_target);
  endtask : t_move
  task automatic t_refuse();
    send(8'h02, INSTR_SET, PARAM_MAX_SPEED, 32'h5, 8'h00);
    no_reply();
    send(8'h01, INSTR_SET, PARAM_MAX_SPEED, 32'h5, 8'h01);
    no_reply();
    chk("speed kept", 32'h3e8, MAX_SPEED);
  endtask : t_refuse
  // Unknown instruction and unsupported move type answer with error status
  task automatic t_errors();
    exp_stat = STATUS_BAD_CMD;
    send(8'h01, 8'h0f, 8'h00, 32'h0, 8'h00);
    reply(8'h0f, 32'h0);
    exp_stat = STATUS_BAD_TYPE;
    moved_q = 1'b0;
    send(8'h01, INSTR_MOVE, 8'h00, 32'h8, 8'h00);
    reply(INSTR_MOVE, 32'h0);
    chk("no move", 32'h0, {31'h0, moved_q});
    exp_stat = STATUS_OK;
  endtask : t_errors
  task automatic t_power();
    do_reset();
    chk("reloaded", 32'ha5a50004, MAX_SPEED);
  endtask : t_power
  initial
  begin
    RST = 1'b1;
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    TX_READY = 1'b0;
    STANDALONE = 1'b0;
    ACT_POS = 32'h0;
    moved_q = 1'b0;
    moved_target = 32'h0;
    exp_stat = STATUS_OK;
    @(posedge REF_CLK);
    do_reset();
    t_set_get();
    t_position();
    t_store_restore();
    t_move();
    t_refuse();
    t_errors();
    t_power();
    final_report();
  end
endmodule : apcd_decoder_tb
